// ===== rtl/adc_cycle_serial_sequencer.sv
// conversion / sleep / data cycle sequencer with serial port
//
// Functional notes
// - a finished conversion drops into sleep on its own
// - sleep with chip select high lasts forever, result kept
// - chip select low in sleep enters the data phase
// - chip select high before any rising clock returns to sleep
// - chip select high after a rising clock aborts, starts conversion
// - shifted word is the conversion just finished
// - output bit changes only on falling serial clock edges
// - input bit sampled on the first 13 rising edges, becomes next configuration
// - after 32 bits a new conversion starts by itself
// - floating clock pin gives internal clock, low pin external clock
// - clock mode set only by pin timing, cycle order unchanged
// - first conversion after new selection is valid, none discarded
// - every conversion includes an offset and full-scale calibration
// - supply low holds an internal reset, keeping result and setup
// - supply recovery gives a 4ms power-on reset clearing registers
// - after power-on: inputs 0/1 differential, 50/60Hz, 1x rate
// - host may load a new setup in the first data phase
// - out-of-range inputs give distinct over and under codes
// - conversion and sleep show status on the output, not data
// - data phase returns result and takes the setup word
// - word: status, zero, sign, 24 result bits, 5 sub bits
// - output high converting, low when ready, released when deselected
// - setup word is 13 bits: channel group and mode group
// - after the last falling edge the output goes high
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_cycle_serial_sequencer #(
  parameter int unsigned POR_CYCLES = `POR_TIME_US * `SYS_MHZ,
  parameter int unsigned CONV_OSC_PERIODS = 2048,
  parameter int unsigned CAL_OSC_PERIODS = 256,
  parameter int unsigned ISCK_HALF = `ISCK_HALF_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_low,
  input wire logic cs_n_pin,
  input wire logic sck_i,
  input wire logic sck_link,
  input wire logic sdi_i,
  input wire logic [29:0] conv_value,
  input wire logic conv_over,
  input wire logic conv_under,
  output logic sck_o,
  output logic sck_oe,
  output logic sdo_o,
  output logic sdo_oe,
  output logic conv_start,
  output logic conv_busy,
  output logic cal_phase,
  output logic sleeping,
  output logic int_sck_mode,
  output logic [12:0] cfg_active
);

  // --------------------------------------------------------------
  // derived timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_PER_OSC = `SYS_HZ / `OSC_HZ;
  localparam int unsigned CONV_CYCLES = CONV_OSC_PERIODS * CLK_PER_OSC;
  localparam int unsigned CAL_CYCLES = CAL_OSC_PERIODS * CLK_PER_OSC;

  adc_seq_pkg::seq_state_e state_r;
  adc_seq_pkg::seq_state_e state_nxt;
  adc_seq_pkg::cfg_word_t cfg_next_r;
  adc_seq_pkg::cfg_word_t cfg_link;
  logic [`TIMER_W-1:0] timer_r;
  logic [`TIMER_W-1:0] conv_len;
  logic [31:0] result_word_r;
  logic cs_s;
  logic cs_prev_r;
  logic sck_s;
  logic supply_s;
  logic [3:0] tgl_s;
  logic [3:0] tgl_prev_r;
  logic [3:0] tgl_ev;
  logic rise_seen_r;
  logic cfg_pend_r;
  logic sel_link_r;
  logic eoc_r;
  logic sdo_link;
  logic cs_fall;
  logic start_nxt;
  logic [15:0] div_r;
  logic [`EDGE_W-1:0] edge_cnt_r;
  logic sck_o_r;
  logic sck_oe_r;
  logic sdo_oe_r;

  // --------------------------------------------------------------
  // crossings into the system clock
  // --------------------------------------------------------------
  logic first_rise_tgl;
  logic first_fall_tgl;
  logic cfg_tgl;
  logic done_tgl;

  bit_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_async({cs_n_pin, sck_i, supply_low}),
    .q_sync({cs_s, sck_s, supply_s})
  );

  bit_sync #(
    .WIDTH(4)
  ) u_tgl_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_async({done_tgl, cfg_tgl, first_fall_tgl, first_rise_tgl}),
    .q_sync(tgl_s)
  );

  serial_link_shifter u_link (
    .sck_link(sck_link),
    .cs_n_pin(cs_n_pin),
    .rst_n(rst_n),
    .sdi_i(sdi_i),
    .tx_word(result_word_r),
    .sdo_bit(sdo_link),
    .cfg_word(cfg_link),
    .first_rise_tgl(first_rise_tgl),
    .first_fall_tgl(first_fall_tgl),
    .cfg_tgl(cfg_tgl),
    .done_tgl(done_tgl)
  );

  // event pulses from toggle changes, chip select edge history
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tgl_prev_r <= 4'h0;
      cs_prev_r <= 1'b1;
    end else begin
      tgl_prev_r <= tgl_s;
      cs_prev_r <= cs_s;
    end
  end

  assign tgl_ev = tgl_s ^ tgl_prev_r;
  assign cs_fall = cs_prev_r & ~cs_s;

  // conversion length halves in double-rate mode
  assign conv_len = cfg_active[`CFG_SPEED_BIT] ? `TIMER_W'(CONV_CYCLES / 2)
                                              : `TIMER_W'(CONV_CYCLES);

  // --------------------------------------------------------------
  // cycle state machine
  // --------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_seq_pkg::ST_HOLD: begin
        if (!supply_s) begin
          state_nxt = adc_seq_pkg::ST_POR;
        end
      end
      adc_seq_pkg::ST_POR: begin
        if (timer_r == `TIMER_W'(POR_CYCLES - 1)) begin
          state_nxt = adc_seq_pkg::ST_CONV;
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (timer_r == conv_len - `TIMER_W'(1)) begin
          state_nxt = adc_seq_pkg::ST_SLEEP;
        end
      end
      adc_seq_pkg::ST_SLEEP: begin
        if (!cs_s) begin
          state_nxt = adc_seq_pkg::ST_DATA;
        end
      end
      adc_seq_pkg::ST_DATA: begin
        if (tgl_ev[3]) begin
          state_nxt = adc_seq_pkg::ST_CONV;
        end else if (cs_s) begin
          if (rise_seen_r || tgl_ev[0]) begin
            state_nxt = adc_seq_pkg::ST_CONV;
          end else begin
            state_nxt = adc_seq_pkg::ST_SLEEP;
          end
        end
      end
      default: begin
        state_nxt = adc_seq_pkg::ST_HOLD;
      end
    endcase
    if (supply_s) begin
      state_nxt = adc_seq_pkg::ST_HOLD;
    end
  end

  assign start_nxt = (state_nxt == adc_seq_pkg::ST_CONV) &&
                     (state_r != adc_seq_pkg::ST_CONV);

  // state register and shared timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= adc_seq_pkg::ST_POR;
      timer_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        timer_r <= '0;
      end else if (state_r == adc_seq_pkg::ST_POR || state_r == adc_seq_pkg::ST_CONV) begin
        timer_r <= timer_r + `TIMER_W'(1);
      end
    end
  end

  // --------------------------------------------------------------
  // result word capture
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_r == adc_seq_pkg::ST_POR) begin
      result_word_r <= '0;
    end else if (state_r == adc_seq_pkg::ST_CONV &&
                 state_nxt == adc_seq_pkg::ST_SLEEP) begin
      result_word_r[`RES_EOC] <= 1'b0;
      result_word_r[`RES_ZERO] <= 1'b0;
      if (conv_over) begin
        result_word_r[`RES_SIGN:0] <= {2'b11, 28'h0000000};
      end else if (conv_under) begin
        result_word_r[`RES_SIGN:0] <= {2'b00, 28'hfffffff};
      end else begin
        result_word_r[`RES_SIGN:0] <= conv_value;
      end
    end
  end

  // --------------------------------------------------------------
  // configuration: power-on value, capture, apply at start
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_r == adc_seq_pkg::ST_POR) begin
      cfg_active <= `CFG_RESET;
      cfg_next_r <= `CFG_RESET;
      cfg_pend_r <= 1'b0;
    end else begin
      if (start_nxt && cfg_pend_r) begin
        cfg_active <= cfg_next_r;
      end
      if (state_r == adc_seq_pkg::ST_DATA && tgl_ev[2]) begin
        cfg_next_r <= cfg_link;
        cfg_pend_r <= 1'b1;
      end else if (start_nxt) begin
        cfg_pend_r <= 1'b0;
      end
    end
  end

  // first rising clock seen in this data phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rise_seen_r <= 1'b0;
    end else if (state_r == adc_seq_pkg::ST_DATA && tgl_ev[0]) begin
      rise_seen_r <= 1'b1;
    end else if (state_r != adc_seq_pkg::ST_DATA) begin
      rise_seen_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // serial clock mode strap
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_sck_mode <= 1'b0;
    end else if (state_r == adc_seq_pkg::ST_POR) begin
      int_sck_mode <= sck_s;
    end else if (cs_fall && state_r != adc_seq_pkg::ST_HOLD) begin
      int_sck_mode <= sck_s;
    end
  end

  // --------------------------------------------------------------
  // internal serial clock: 32 low-to-high pulses per data phase
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_r != adc_seq_pkg::ST_DATA || !int_sck_mode || cs_s) begin
      div_r <= '0;
      edge_cnt_r <= '0;
      sck_o_r <= 1'b0;
      sck_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= 1'b1;
      if (edge_cnt_r != `SCK_EDGES) begin
        if (div_r == 16'(ISCK_HALF - 1)) begin
          div_r <= '0;
          sck_o_r <= ~sck_o_r;
          edge_cnt_r <= edge_cnt_r + `EDGE_W'(1);
        end else begin
          div_r <= div_r + 16'h0001;
        end
      end
    end
  end

  assign sck_o = sck_o_r;
  assign sck_oe = sck_oe_r;

  // --------------------------------------------------------------
  // output line: status or data
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eoc_r <= 1'b1;
      sel_link_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      eoc_r <= (state_nxt != adc_seq_pkg::ST_SLEEP) &&
               (state_nxt != adc_seq_pkg::ST_DATA);
      sdo_oe_r <= ~cs_s;
      if (state_nxt != adc_seq_pkg::ST_DATA) begin
        sel_link_r <= 1'b0;
      end else if (tgl_ev[1]) begin
        sel_link_r <= 1'b1;
      end
    end
  end

  assign sdo_o = sel_link_r ? sdo_link : eoc_r;
  assign sdo_oe = sdo_oe_r;

  // --------------------------------------------------------------
  // status outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
      cal_phase <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      conv_start <= start_nxt;
      conv_busy <= (state_nxt == adc_seq_pkg::ST_CONV);
      // calibration closes every conversion, whatever the channel
      cal_phase <= (state_r == adc_seq_pkg::ST_CONV) &&
                   (timer_r >= conv_len - `TIMER_W'(CAL_CYCLES));
      sleeping <= (state_nxt == adc_seq_pkg::ST_SLEEP) && cs_s;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/adc_seq_pkg.sv
// types shared by the converter cycle sequencer
package adc_seq_pkg;

  // --------------------------------------------------------------
  // cycle states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_POR,
    ST_CONV,
    ST_SLEEP,
    ST_DATA
  } seq_state_e;

  typedef logic [12:0] cfg_word_t;

endpackage

// ===== rtl/adc_seq_regs.svh
// constants for the converter cycle sequencer
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// --------------------------------------------------------------
// serial word layout
// --------------------------------------------------------------
`define WORD_BITS 32
`define CNT_W 5
`define LAST_BIT 5'h1f
`define FIRST_DATA_BIT 5'h1e
`define CFG_BITS 13
`define RES_EOC 31
`define RES_ZERO 30
`define RES_SIGN 29
`define RES_MSB 28
`define VALUE_BITS 30

// --------------------------------------------------------------
// configuration word fields and power-on value
// --------------------------------------------------------------
`define CFG_CHAN_MSB 12
`define CFG_CHAN_LSB 8
`define CFG_SPEED_BIT 4
`define CFG_RESET 13'h0000

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define SYS_MHZ 200
`define SYS_HZ 200000000
`define OSC_HZ 307200
`define POR_TIME_US 4000
`define ISCK_HALF_DEFAULT 16
`define TIMER_W 24
`define SCK_EDGES 7'h40
`define EDGE_W 7

`endif

// ===== rtl/bit_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage only feeds the second
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= d_async[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign q_sync = sync_r;
endmodule
`default_nettype wire

// ===== rtl/serial_link_shifter.sv
// shift logic clocked by the serial clock wire
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module serial_link_shifter (
  input wire logic sck_link,
  input wire logic cs_n_pin,
  input wire logic rst_n,
  input wire logic sdi_i,
  input wire logic [31:0] tx_word,
  output logic sdo_bit,
  output logic [12:0] cfg_word,
  output logic first_rise_tgl,
  output logic first_fall_tgl,
  output logic cfg_tgl,
  output logic done_tgl
);
  logic link_clr;
  logic [`CNT_W-1:0] rise_cnt_r;
  logic [`CNT_W-1:0] fall_cnt_r;
  logic risen_r;

  // frame counters clear while chip select is high
  assign link_clr = cs_n_pin | ~rst_n;

  // --------------------------------------------------------------
  // rising edge side: capture serial input
  // --------------------------------------------------------------
  always_ff @(posedge sck_link or posedge link_clr) begin
    if (link_clr) begin
      rise_cnt_r <= '0;
      risen_r <= 1'b0;
    end else begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
      risen_r <= 1'b1;
    end
  end

  // sample input bits and flag first rise and full config word
  always_ff @(posedge sck_link or negedge rst_n) begin
    if (!rst_n) begin
      cfg_word <= `CFG_RESET;
      first_rise_tgl <= 1'b0;
      cfg_tgl <= 1'b0;
    end else if (!cs_n_pin) begin
      if (rise_cnt_r < 5'(`CFG_BITS)) begin
        cfg_word <= {cfg_word[11:0], sdi_i};
      end
      if (rise_cnt_r == 5'h00) begin
        first_rise_tgl <= ~first_rise_tgl;
      end
      if (rise_cnt_r == 5'(`CFG_BITS - 1)) begin
        cfg_tgl <= ~cfg_tgl;
      end
    end
  end

  // --------------------------------------------------------------
  // falling edge side: drive output bits
  // --------------------------------------------------------------
  always_ff @(negedge sck_link or posedge link_clr) begin
    if (link_clr) begin
      fall_cnt_r <= '0;
      sdo_bit <= 1'b1;
    end else if (risen_r) begin // own clock starting low is no bit edge
      fall_cnt_r <= fall_cnt_r + 5'h01;
      if (fall_cnt_r == `LAST_BIT) begin
        sdo_bit <= 1'b1;
      end else begin
        sdo_bit <= tx_word[`FIRST_DATA_BIT - fall_cnt_r];
      end
    end
  end

  // flag first fall and end of the 32-bit word
  always_ff @(negedge sck_link or negedge rst_n) begin
    if (!rst_n) begin
      first_fall_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end else if (!cs_n_pin && risen_r) begin
      if (fall_cnt_r == 5'h00) begin
        first_fall_tgl <= ~first_fall_tgl;
      end
      if (fall_cnt_r == `LAST_BIT) begin
        done_tgl <= ~done_tgl;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/adc_cycle_serial_sequencer_bench.sv
// self-checking bench of the converter cycle sequencer
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_cycle_serial_sequencer_bench;
  logic clk_sys, rst_n, supply_low, eoc;
  logic pat = 1'b0, conv_over = 1'b0, conv_under = 1'b0;
  logic sck_o, sck_oe, sdo_o, sdo_oe, conv_start, conv_busy, cal_phase;
  logic sleeping, int_sck_mode, cs_n, sck_drv, sck_en, sdi, sck_wire, sdo_wire;
  logic [29:0] conv_value = '0;
  logic [12:0] cfg_active, cfg, cfg_exp;
  logic [31:0] got, exp_w, mask;
  bit hung;
  int fail_count, tests_run, s0, nr, tmp;
  int starts = 0;
  int cals = 0;

  // ----------------------------------------
  // design, host and wires
  // ----------------------------------------
  adc_cycle_serial_sequencer #(.POR_CYCLES(200), .CONV_OSC_PERIODS(2),
    .CAL_OSC_PERIODS(1), .ISCK_HALF(16)) uut (.clk_sys, .rst_n, .supply_low,
    .cs_n_pin(cs_n), .sck_i(sck_wire), .sck_link(sck_wire), .sdi_i(sdi), .conv_value,
    .conv_over, .conv_under, .sck_o, .sck_oe, .sdo_o, .sdo_oe, .conv_start, .conv_busy,
    .cal_phase, .sleeping, .int_sck_mode, .cfg_active);
  host_link_model host (.sck_wire, .sdo_wire, .cs_n, .sck_drv, .sck_en, .sdi);

  // clock pin pulled up, released data line wanders
  assign sck_wire = sck_oe ? sck_o : (sck_en ? sck_drv : 1'b1);
  assign sdo_wire = sdo_oe ? sdo_o : pat;

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // analog model: new reading per conversion, over and under in turn
  always @(posedge clk_sys) begin
    pat <= ~pat;
    // calibration cycles seen in the current conversion
    if (conv_start === 1'b1) begin
      cals <= 0;
    end else if (cal_phase === 1'b1) begin
      cals <= cals + 1;
    end
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      conv_value <= 30'($urandom);
      conv_over <= (starts % 4 == 1);
      conv_under <= (starts % 4 == 2);
    end
  end

  // ----------------------------------------
  // model, compares and waits
  // ----------------------------------------
  function automatic logic [31:0] model_word();
    if (conv_over) return 32'h3000_0000;
    if (conv_under) return 32'h0fff_ffff;
    return {2'b00, conv_value};
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    check(g, e);
  endtask
  task automatic chk_cfg(input logic [12:0] g, input logic [12:0] e);
    check({19'h0, g}, {19'h0, e});
  endtask
  task automatic chk_flag(input logic g, input logic e);
    check({31'h0, g}, {31'h0, e});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // wait for sleep, or for a start beyond count s, within lim cycles
  task automatic wait_ev(input bit want_sleep, input int s, input int lim);
    int n;
    n = 0;
    while ((want_sleep ? sleeping !== 1'b1 : starts == s) && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    tmp = $urandom(32'hd75c);
    {fail_count, tests_run} = '0;
    {rst_n, supply_low} = '0;
    cfg_exp = 13'h0000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_ev(0, 0, 400);
    repeat (4) @(posedge clk_sys);
    chk_cfg(cfg_active, 13'h0000);
    host.frame(0, 0, 13'h0, got, eoc, hung);
    chk_flag(eoc, 1'b1);
    wait_ev(1, 0, 3000);
    s0 = starts;
    host.frame(0, 0, 13'h0, got, eoc, hung);
    chk_flag(eoc, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk_flag(sleeping, 1'b1);
    chk_word(starts, s0);
    for (int i = 0; i < 7; i++) begin
      wait_ev(1, 0, 3000);
      repeat (200) @(posedge clk_sys);
      chk_word(cals, `SYS_HZ / `OSC_HZ);
      exp_w = model_word();
      cfg = 13'($urandom);
      s0 = starts;
      nr = (i == 3) ? 5 : (i == 4) ? 20 : (i == 5) ? 1 : 32;
      host.frame(i == 2, nr, cfg, got, eoc, hung);
      if (hung) begin
        fail_count++;
        tally_and_finish();
      end
      mask = 32'hffff_ffff << (32 - nr);
      chk_word(got & mask, exp_w & mask);
      chk_flag(int_sck_mode, i == 2);
      if (nr == 32) begin
        chk_flag(eoc, 1'b1);
      end
      wait_ev(0, s0, 100);
      repeat (4) @(posedge clk_sys);
      if (nr >= 13) begin
        cfg_exp = cfg;
      end
      chk_cfg(cfg_active, cfg_exp);
    end
    s0 = starts;
    supply_low <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk_flag(conv_busy | sleeping, 1'b0);
    supply_low <= 1'b0;
    wait_ev(0, s0, 400);
    repeat (4) @(posedge clk_sys);
    chk_cfg(cfg_active, 13'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== testbench/adc_seq_chk.sv
// port timing checker for the converter cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_chk #(
  parameter int unsigned POR_CYCLES = 200,
  parameter int unsigned CONV_OSC_PERIODS = 2,
  parameter int unsigned CAL_OSC_PERIODS = 1,
  parameter int unsigned ISCK_HALF = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_low,
  input wire logic cs_n_pin,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sck_oe,
  input wire logic int_sck_mode,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic sleeping,
  input wire logic [12:0] cfg_active
);
  // ----------------------------------------
  // cycle and pin assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // conversion entry is one pulse, then busy
  AST_START_ONE: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  AST_START_BUSY: assert property (conv_start |-> ##[0:2] conv_busy)
    else $error("busy missing after start");
  // a finished conversion sleeps, and sleep lasts while deselected
  AST_AUTO_SLEEP: assert property ($fell(conv_busy) && cs_n_pin && !supply_low
    |-> ##[0:3] sleeping) else $error("no sleep after conversion");
  AST_SLEEP_STAYS: assert property (sleeping && cs_n_pin && !supply_low |=> sleeping)
    else $error("sleep left while deselected");
  // output driver follows the select pin
  AST_SDO_RELEASE: assert property (cs_n_pin [*5] |-> !sdo_oe)
    else $error("output driven while deselected");
  AST_SDO_DRIVE: assert property (!cs_n_pin [*5] |-> sdo_oe)
    else $error("output not driven while selected");
  AST_BUSY_EOC: assert property (conv_busy && !cs_n_pin && sdo_oe |-> sdo_o)
    else $error("status low while converting");
  AST_SCK_OWNER: assert property (sck_oe |-> int_sck_mode)
    else $error("clock driven in external mode");
  AST_CFG_STEADY: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2)
    |-> $stable(cfg_active)) else $error("setup changed mid conversion");
  AST_HOLD_IDLE: assert property (supply_low [*6] |-> !conv_busy && !sleeping)
    else $error("running while supply low");
endmodule

bind adc_cycle_serial_sequencer adc_seq_chk #(.POR_CYCLES(POR_CYCLES),
  .CONV_OSC_PERIODS(CONV_OSC_PERIODS), .CAL_OSC_PERIODS(CAL_OSC_PERIODS),
  .ISCK_HALF(ISCK_HALF)) chk (.clk_sys, .rst_n, .supply_low, .cs_n_pin, .sdo_o,
  .sdo_oe, .sck_oe, .int_sck_mode, .conv_start, .conv_busy, .sleeping, .cfg_active);
`default_nettype wire

// ===== testbench/host_link_model.sv
// host controller model on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  input wire logic sck_wire,
  input wire logic sdo_wire,
  output logic cs_n,
  output logic sck_drv,
  output logic sck_en,
  output logic sdi
);
  // low clock pin at power-up selects the external clock
  initial begin
    cs_n = 1'b1;
    sck_drv = 1'b0;
    sck_en = 1'b1;
    sdi = 1'b0;
  end

  // bounded wait for the clock wire to reach a level
  task automatic wait_lvl(input logic v, inout int n);
    while (sck_wire !== v && n > 0) begin
      #1;
      n--;
    end
  endtask

  // one select frame with nrise rising clock edges
  task automatic frame(input bit int_mode, input int nrise, input logic [12:0] cfg,
      output logic [31:0] got, output logic eoc, output bit hung);
    int n;
    n = 20000;
    got = '0;
    sck_en = !int_mode; // floating pin at select fall picks internal clock
    sdi = cfg[12]; // setup word loaded only in frames with 13 or more rising edges
    #57;
    cs_n = 1'b0;
    if (int_mode) begin
      wait_lvl(1'b0, n);
    end else begin
      #97;
    end
    eoc = sdo_wire;
    for (int k = 0; k < nrise; k++) begin
      if (int_mode) begin
        wait_lvl(1'b1, n);
      end else begin
        #40;
      end
      got[31-k] = sdo_wire; // sampled at the rising edge
      sck_drv = !int_mode;
      if (int_mode) begin
        wait_lvl(1'b0, n);
      end else begin
        #80;
      end
      sck_drv = 1'b0;
      #40;
      sdi = (k < 12) ? cfg[11-k] : ~sdi;
    end
    #60;
    if (nrise == 32) begin
      eoc = sdo_wire; // level after the last falling edge
    end
    cs_n = 1'b1;
    #200;
    sck_en = 1'b1;
    hung = (n <= 0);
  endtask
endmodule
`default_nettype wire
